/* File: verilog/hw_limit_timer_map.svh */
// Register indices, field positions, reset values and mode codes of the limit timer
`ifndef HW_LIMIT_TIMER_MAP_SVH
`define HW_LIMIT_TIMER_MAP_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define COUNT_IDX 10'h028c
`define PERIOD_IDX 10'h028d
`define CONTROL_IDX 10'h028e
`define HLIMIT_IDX 10'h028f

// ==========================================================
// Field positions
`define CONTROL_ON_BIT 7
`define HLIMIT_PRESCALER_OUTPUT_SYNC_BIT 7
`define HLIMIT_CPOL_BIT 6
`define HLIMIT_RUN_BIT_CLOCK_SYNC_BIT 5
`define HLIMIT_MODE_MSB 4

// ==========================================================
// Reset values
`define COUNT_RESET 8'h00
`define PERIOD_RESET 8'hff
`define CONTROL_RESET 8'h00
`define HLIMIT_RESET 8'h00

// ==========================================================
// Mode codes
`define MODE_SW_GATE 5'h00
`define MODE_GATE_HIGH_STOP 5'h01
`define MODE_GATE_LOW_STOP 5'h02
`define MODE_EDGE_LIM_ANY 5'h03
`define MODE_EDGE_LIM_RISE 5'h04
`define MODE_EDGE_LIM_FALL 5'h05
`define MODE_LVL_LIM_LOW 5'h06
`define MODE_LVL_LIM_HIGH 5'h07
`define MODE_ONESHOT_SW 5'h08
`define MODE_ONESHOT_RISE 5'h09
`define MODE_ONESHOT_FALL 5'h0a
`define MODE_ONESHOT_ANY 5'h0b
`define MODE_OS_LIM_RISE 5'h0c
`define MODE_OS_LIM_FALL 5'h0d
`define MODE_OS_LVL_EDGE_LOW 5'h0e
`define MODE_OS_LVL_EDGE_HIGH 5'h0f
`define MODE_MONO_RISE 5'h11
`define MODE_MONO_FALL 5'h12
`define MODE_MONO_ANY 5'h13
`define MODE_OS_LVL_LOW 5'h16
`define MODE_OS_LVL_HIGH 5'h17

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: verilog/hw_limit_timer_pkg.sv */
// Types shared by the limit timer design
`default_nettype none
package hw_limit_timer_pkg;
	typedef logic [7:0] byte_type;
	typedef logic [4:0] mode_type;
	typedef logic [11:0] addr_type;
	typedef logic [31:0] word_type;
	typedef logic [1:0] resp_type;
endpackage : hw_limit_timer_pkg
`default_nettype wire

/* File: verilog/hw_limit_timer_modes.sv */
// Hardware limit timer with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "hw_limit_timer_map.svh"

// Notes on behaviour
// - Hardware gate modes count like software gate, external signal may also pause.
// - Mode 1 halts while signal high; mode 2 halts while signal low.
// - Edge limit modes clear count on any, rising or falling edge (3, 4, 5).
// - After an early edge reset the period restarts two clocks later.
// - Level limit modes clear count while signal low (6) or high (7).
// - In level limit modes the signal does nothing while run bit is clear.
// - Level limit: count clears on period match or two clocks after reset level.
// - Level limit: counting resumes after match, or two clocks after reset level ends.
// - Mode 8: period match clears count and run bit; software restarts each cycle.
// - Mode 8: clearing then setting run bit mid-cycle pauses then resumes.
// - Edge one shot modes start on edge after run set; match clears run bit.
// - Edge one shot: after run bit cleared, a fresh edge is needed to resume.
// - Edge limit one shot: first edge starts, later edges reset, resume two clocks on.
// - Edge limit one shot: match clears count and run; edges ignored while run clear.
// - Level-reset edge one shot: held clear at reset level, start on active edge.
// - Level-reset edge one shot: match clears run; new edge needed after re-enable.
// - Monostable modes start on edge after run set, stop incrementing at match.
// - Level limit one shot: held clear at reset level; start when run and inactive.
// - Level limit one shot: match clears count and run; stays reset until both again.
// - With prescaler sync set, timer frozen in sleep, count and period kept.
// - With prescaler sync clear, timer keeps running in sleep on its clock.
// - Monostable: clock after match stops count at zero, run bit kept.
// - Every mode: clock after count equals period clears the count.
// - Software gate: count advances on each input clock while run set, else holds.
// - With run-bit sync enabled, operation starts two input clocks after run set.
module hw_limit_timer_modes
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic timer_tick_i,
	input wire logic sleep_i,
	input wire logic ext_reset_signal_i,
	output var hw_limit_timer_pkg::byte_type count_value_o,
	output logic period_match_o,
	output logic run_o,
	input wire hw_limit_timer_pkg::addr_type s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire hw_limit_timer_pkg::word_type s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire hw_limit_timer_pkg::addr_type s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output var hw_limit_timer_pkg::word_type s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import hw_limit_timer_pkg::*;

	// ==========================================================
	// Registers and timer state
	byte_type count_register;
	byte_type period_register;
	byte_type control_reg;
	byte_type hlimit_reg;
	logic started, ers_meta, ers_sync, ers_prev;
	logic [1:0] on_sync;

	// ==========================================================
	// Bus write capture
	logic aw_held, w_held, do_write;
	addr_type aw_addr;
	word_type w_data;
	logic [3:0] w_strb;
	addr_type rd_addr;

	// ==========================================================
	// Combinational timer decisions
	mode_type mode;
	logic run_bit, on_eff, tick, match, rise, fall, edge_hit, at_reset_level;
	logic next_started, next_clear_on, next_match;
	byte_type next_count;

	assign mode = hlimit_reg[`HLIMIT_MODE_MSB:0];
	assign run_bit = control_reg[`CONTROL_ON_BIT];
	// Sleep only stops the tick when the prescaler output is synchronised
	assign tick = timer_tick_i & ~(sleep_i & hlimit_reg[`HLIMIT_PRESCALER_OUTPUT_SYNC_BIT]);
	// Run bit may be delayed two input clocks to keep enable glitch free
	assign on_eff = hlimit_reg[`HLIMIT_RUN_BIT_CLOCK_SYNC_BIT] ? (run_bit & on_sync[1]) : run_bit;
	assign match = (count_register == period_register);
	assign rise = ers_sync & ~ers_prev;
	assign fall = ~ers_sync & ers_prev;
	// Odd codes reset on high level, even codes on low level
	assign at_reset_level = mode[0] ? ers_sync : ~ers_sync;

	always_comb
	begin
		case (mode)
			`MODE_EDGE_LIM_ANY, `MODE_ONESHOT_ANY, `MODE_MONO_ANY:
				edge_hit = rise | fall;
			`MODE_EDGE_LIM_RISE, `MODE_ONESHOT_RISE, `MODE_OS_LIM_RISE, `MODE_MONO_RISE, `MODE_OS_LVL_EDGE_LOW:
				edge_hit = rise;
			`MODE_EDGE_LIM_FALL, `MODE_ONESHOT_FALL, `MODE_OS_LIM_FALL, `MODE_MONO_FALL, `MODE_OS_LVL_EDGE_HIGH:
				edge_hit = fall;
			default:
				edge_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		next_count = count_register;
		next_started = started;
		next_clear_on = 1'b0;
		next_match = 1'b0;
		case (mode)
			`MODE_SW_GATE, `MODE_GATE_HIGH_STOP, `MODE_GATE_LOW_STOP:
			begin
				// Gate modes pause, never clear; match still wraps
				if (on_eff && !(mode == `MODE_GATE_HIGH_STOP && ers_sync)
					&& !(mode == `MODE_GATE_LOW_STOP && !ers_sync))
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
				end
			end
			`MODE_EDGE_LIM_ANY, `MODE_EDGE_LIM_RISE, `MODE_EDGE_LIM_FALL:
			begin
				if (on_eff)
				begin
					next_match = match & ~edge_hit;
					// Edge seen two clocks late via the synchroniser, period restarts from zero
					if (edge_hit)
						next_count = 8'h00;
					else
						next_count = match ? 8'h00 : count_register + 8'h01;
				end
			end
			`MODE_LVL_LIM_LOW, `MODE_LVL_LIM_HIGH:
			begin
				// Nothing happens while run is clear, the signal included
				if (on_eff)
				begin
					next_match = match & ~at_reset_level;
					if (at_reset_level)
						next_count = 8'h00;
					else
						next_count = match ? 8'h00 : count_register + 8'h01;
				end
			end
			`MODE_ONESHOT_SW:
			begin
				// Pausing keeps the count, so the cycle completes later
				if (on_eff)
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
					next_clear_on = match;
				end
			end
			`MODE_ONESHOT_RISE, `MODE_ONESHOT_FALL, `MODE_ONESHOT_ANY,
			`MODE_MONO_RISE, `MODE_MONO_FALL, `MODE_MONO_ANY:
			begin
				if (!on_eff)
					next_started = 1'b0;
				else if (!started)
					next_started = edge_hit;
				else
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
					next_started = ~match;
					next_clear_on = match & ~mode[4];
				end
			end
			`MODE_OS_LIM_RISE, `MODE_OS_LIM_FALL:
			begin
				// Edges ignored until the run bit is set
				if (!on_eff)
					next_started = 1'b0;
				else if (!started)
					next_started = edge_hit;
				else if (edge_hit)
					next_count = 8'h00;
				else
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
					next_started = ~match;
					next_clear_on = match;
				end
			end
			`MODE_OS_LVL_EDGE_LOW, `MODE_OS_LVL_EDGE_HIGH:
			begin
				if (at_reset_level)
				begin
					next_count = 8'h00;
					next_started = 1'b0;
				end
				else if (!on_eff)
					next_started = 1'b0;
				else if (!started)
					next_started = edge_hit;
				else
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
					next_started = ~match;
					next_clear_on = match;
				end
			end
			`MODE_OS_LVL_LOW, `MODE_OS_LVL_HIGH:
			begin
				if (at_reset_level)
					next_count = 8'h00;
				else if (on_eff)
				begin
					next_match = match;
					next_count = match ? 8'h00 : count_register + 8'h01;
					next_clear_on = match;
				end
			end
			default:
				next_count = count_register;
		endcase
	end

	// ==========================================================
	// External signal synchroniser, first stage read only by second
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ers_meta <= 1'b0;
			ers_sync <= 1'b0;
		end
		else
		begin
			ers_meta <= ext_reset_signal_i;
			ers_sync <= ers_meta;
		end
	end

	// Edge history and run-bit delay advance on timer ticks only
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ers_prev <= 1'b0;
			on_sync <= 2'b00;
		end
		else if (tick)
		begin
			ers_prev <= ers_sync;
			on_sync <= {on_sync[0], run_bit};
		end
	end

	// ==========================================================
	// Counter; a software write wins over the timer
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			count_register <= `COUNT_RESET;
			started <= 1'b0;
			period_match_o <= 1'b0;
		end
		else
		begin
			period_match_o <= tick & next_match;
			if (do_write && aw_addr[11:2] == `COUNT_IDX && w_strb[0])
				count_register <= w_data[7:0];
			else if (tick)
				count_register <= next_count;
			if (tick)
				started <= next_started;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			period_register <= `PERIOD_RESET;
			hlimit_reg <= `HLIMIT_RESET;
		end
		else if (do_write && w_strb[0])
		begin
			if (aw_addr[11:2] == `PERIOD_IDX)
				period_register <= w_data[7:0];
			if (aw_addr[11:2] == `HLIMIT_IDX)
				hlimit_reg <= w_data[7:0];
		end
	end

	// Software write of the run bit takes effect over the hardware clear
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			control_reg <= `CONTROL_RESET;
		else if (do_write && aw_addr[11:2] == `CONTROL_IDX && w_strb[0])
			control_reg <= w_data[7:0];
		else if (tick && next_clear_on)
			control_reg[`CONTROL_ON_BIT] <= 1'b0;
	end

	assign count_value_o = count_register;
	assign run_o = run_bit;

	// ==========================================================
	// AXI4-Lite write channel
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[11:2] >= `COUNT_IDX && aw_addr[11:2] <= `HLIMIT_IDX)
					? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read channel, one cycle after address
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (rd_addr[11:2])
				`COUNT_IDX:
					s_axi_rdata <= {24'h00_0000, count_register};
				`PERIOD_IDX:
					s_axi_rdata <= {24'h00_0000, period_register};
				`CONTROL_IDX:
					s_axi_rdata <= {24'h00_0000, control_reg};
				`HLIMIT_IDX:
					s_axi_rdata <= {24'h00_0000, hlimit_reg};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule : hw_limit_timer_modes
`default_nettype wire

/* File: dv/hw_limit_timer_properties.sv */
// Port checker for the limit timer
`timescale 1ns/1ns
`default_nettype none
module hw_limit_timer_properties
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] count_value_o,
	input wire logic period_match_o,
	input wire logic run_o,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// ========
	// Bus answers
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |-> ##[1:2] s_axi_bvalid)
		else $error("no write answer");
	bvalid_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write answer dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// ========
	// Timer
	count_step_a: assert property ($changed(count_value_o) && !$rose(s_axi_bvalid) |->
		count_value_o == $past(count_value_o) + 8'h01 || count_value_o == 8'h00)
		else $error("count jumped");
	match_clear_a: assert property (period_match_o && !$rose(s_axi_bvalid) |-> count_value_o == 8'h00)
		else $error("count not cleared at match");
	run_set_a: assert property ($rose(run_o) |-> $rose(s_axi_bvalid))
		else $error("run set without software");
	run_clear_a: assert property ($fell(run_o) && !$rose(s_axi_bvalid) |-> period_match_o)
		else $error("run cleared without match");
	cover property (period_match_o && run_o);
	cover property ($fell(run_o));
	cover property (s_axi_rvalid && s_axi_rready);
endmodule : hw_limit_timer_properties
`default_nettype wire

/* File: dv/ext_signal_source.sv */
// External reset signal and timer tick source
`timescale 1ns/1ns
`default_nettype none
module ext_signal_source
#(
	parameter int TICK_DIV = 1
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	output logic ext_o,
	output logic tick_o
);
	int div;
	logic level = 1'h0;
	assign ext_o = level;
	// ========
	// Tick pulse; a divider above one makes a slow timer clock
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			div <= 0;
			tick_o <= 1'h0;
		end
		else
		begin
			div <= (div + 1 >= TICK_DIV) ? 0 : div + 1;
			tick_o <= (div == 0);
		end
	end
	// Level changes on a clk_i edge, yet the timer still passes it through its synchroniser
	task automatic drive(input logic v);
		@(posedge clk_i);
		level <= v;
	endtask : drive
endmodule : ext_signal_source
`default_nettype wire

/* File: dv/hw_limit_timer_modes_tb.sv */
// Self-checking bench for the limit timer
`timescale 1ns/1ns
`default_nettype none
`include "hw_limit_timer_map.svh"
module hw_limit_timer_modes_tb;
	logic clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic sleep_i = 1'h0;
	logic timer_tick_i, ext_reset_signal_i, period_match_o, run_o;
	logic [7:0] count_value_o, got, mx;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, strb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [4:0] lv_list [4] = '{5'h01, 5'h02, 5'h06, 5'h07};
	// Bit 5 marks a falling start edge
	logic [5:0] os_list [12] = '{6'h09, 6'h2a, 6'h0b, 6'h0c, 6'h2d, 6'h0e, 6'h2f, 6'h11, 6'h32, 6'h13, 6'h16, 6'h37};
	int fail_count = 0;
	int total_checks = 0;
	always #50 clk_i = ~clk_i;
	ext_signal_source src (.clk_i, .resetn_i, .ext_o(ext_reset_signal_i), .tick_o(timer_tick_i));
	hw_limit_timer_modes dut (.clk_i, .resetn_i, .timer_tick_i, .sleep_i, .ext_reset_signal_i, .count_value_o,
		.period_match_o, .run_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ========
	// Tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic tmo();
		fail_count++;
		$display("[ERR] %0t wait ran out", $time);
		close_out();
	endtask : tmo
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		int n = 0;
		@(posedge clk_i);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'h0;
		resp = s_axi_bresp;
		if (n >= 50) tmo();
	endtask : wr
	task automatic rd(input logic [9:0] idx);
		int n = 0;
		@(posedge clk_i);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'h0;
		got = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		if (n >= 50) tmo();
	endtask : rd
	task automatic wait_match(input int lim);
		int n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (!period_match_o && n < lim);
		if (n >= lim) tmo();
	endtask : wait_match
	// Settle past the synchroniser, then see whether the count moves
	task automatic held(input logic moving);
		logic [7:0] c;
		repeat (4) @(posedge clk_i);
		c = count_value_o;
		repeat (7) @(posedge clk_i);
		chk({7'h00, count_value_o !== c}, {7'h00, moving});
	endtask : held
	task automatic arm(input logic [7:0] hl, input logic [7:0] pr);
		wr(`CONTROL_IDX, 8'h00);
		wr(`COUNT_IDX, 8'h00);
		wr(`PERIOD_IDX, pr);
		wr(`HLIMIT_IDX, hl);
	endtask : arm
	// ========
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'h1;
		rd(`COUNT_IDX);
		chk(got, 8'h00);
		rd(`PERIOD_IDX);
		chk(got, 8'hff);
		rd(`CONTROL_IDX);
		chk(got, 8'h00);
		rd(`HLIMIT_IDX);
		chk(got, 8'h00);
		rd(10'h3ff);
		chk({6'h00, resp}, 8'h02);
		strb = 4'h0;
		wr(`PERIOD_IDX, 8'h55);
		strb = 4'hf;
		rd(`PERIOD_IDX);
		chk(got, 8'hff);
		$display("registers done");
		arm(8'h00, 8'h05);
		wr(`CONTROL_IDX, 8'h80);
		held(1'h1);
		wait_match(50);
		mx = 8'h00;
		repeat (30)
		begin
			@(posedge clk_i);
			if (count_value_o > mx) mx = count_value_o;
		end
		chk(mx, 8'h05);
		foreach (lv_list[i])
		begin
			wr(`HLIMIT_IDX, {3'h0, lv_list[i]});
			src.drive(lv_list[i][0]);
			held(1'h0);
			if (i > 1) chk(count_value_o, 8'h00);
			src.drive(!lv_list[i][0]);
			held(1'h1);
		end
		wr(`CONTROL_IDX, 8'h00);
		mx = count_value_o;
		src.drive(1'h1);
		held(1'h0);
		chk(count_value_o, mx);
		arm(8'h03, 8'hff);
		wr(`CONTROL_IDX, 8'h80);
		for (int m = 3; m < 6; m++)
		begin
			wr(`HLIMIT_IDX, m[7:0]);
			src.drive(m == 5);
			repeat (20) @(posedge clk_i);
			src.drive(m != 5);
			repeat (5) @(posedge clk_i);
			chk({7'h00, count_value_o < 8'h08}, 8'h01);
		end
		$display("gate and limit done");
		arm(8'h08, 8'h03);
		wr(`CONTROL_IDX, 8'h80);
		wait_match(50);
		repeat (2) @(posedge clk_i);
		chk({7'h00, run_o}, 8'h00);
		foreach (os_list[i])
		begin
			src.drive(os_list[i][5]);
			arm({3'h0, os_list[i][4:0]}, 8'h03);
			wr(`CONTROL_IDX, 8'h80);
			held(1'h0);
			src.drive(!os_list[i][5]);
			wait_match(50);
			repeat (2) @(posedge clk_i);
			chk({7'h00, run_o}, {7'h00, os_list[i][4] & !os_list[i][2]});
			held(1'h0);
		end
		$display("one shot done");
		arm(8'h08, 8'h20);
		wr(`CONTROL_IDX, 8'h80);
		repeat (5) @(posedge clk_i);
		wr(`CONTROL_IDX, 8'h00);
		held(1'h0);
		chk({7'h00, count_value_o != 8'h00}, 8'h01);
		wr(`CONTROL_IDX, 8'h80);
		wait_match(60);
		repeat (2) @(posedge clk_i);
		chk({7'h00, run_o}, 8'h00);
		src.drive(1'h0);
		arm(8'h09, 8'h40);
		wr(`CONTROL_IDX, 8'h80);
		src.drive(1'h1);
		repeat (6) @(posedge clk_i);
		wr(`CONTROL_IDX, 8'h00);
		wr(`CONTROL_IDX, 8'h80);
		held(1'h0);
		src.drive(1'h0);
		src.drive(1'h1);
		held(1'h1);
		arm(8'h0c, 8'h40);
		src.drive(1'h0);
		src.drive(1'h1);
		repeat (4) @(posedge clk_i);
		wr(`CONTROL_IDX, 8'h80);
		held(1'h0);
		src.drive(1'h0);
		src.drive(1'h1);
		repeat (12) @(posedge clk_i);
		src.drive(1'h0);
		src.drive(1'h1);
		repeat (5) @(posedge clk_i);
		chk({7'h00, count_value_o < 8'h08}, 8'h01);
		chk({7'h00, run_o}, 8'h01);
		arm(8'h20, 8'hff);
		wr(`CONTROL_IDX, 8'h80);
		repeat (2) @(negedge clk_i);
		chk(count_value_o, 8'h00);
		@(negedge clk_i);
		chk(count_value_o, 8'h01);
		$display("restart and sync done");
		arm(8'h80, 8'hff);
		wr(`CONTROL_IDX, 8'h80);
		sleep_i <= 1'h1;
		held(1'h0);
		wr(`HLIMIT_IDX, 8'h00);
		held(1'h1);
		$display("sleep done");
		close_out();
	end
endmodule : hw_limit_timer_modes_tb
bind hw_limit_timer_modes hw_limit_timer_properties props (.clk_i, .resetn_i, .count_value_o, .period_match_o,
	.run_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
